/* shared/sched_defs.svh */
/*
  Constants for the clause and wavefront scheduler: clause limits,
  switch cost, issue width, pair cadence and counter widths.
  Assumes it is included by bare name from the design files.
*/
`ifndef SCHED_DEFS_SVH
`define SCHED_DEFS_SVH

// -----------------------------------------------------------------
// clause formation
// -----------------------------------------------------------------
`define ALU_CLAUSE_MAX 128
`define CLAUSE_SWITCH_CYC 40

// -----------------------------------------------------------------
// issue and pair cadence
// -----------------------------------------------------------------
`define ISSUE_SLOTS 5
`define PAIR_QUARTERS 4
`define REG_READ_LAT 8

// -----------------------------------------------------------------
// sizing
// -----------------------------------------------------------------
`define WAVE_COUNT 4
`define FETCH_CNT_W 8

`endif

/* shared/sched_pkg.sv */
/*
  Types shared by the scheduler files: scheduler states and
  instruction classes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sched_pkg;

  typedef enum logic [3:0] {
    S_IDLE   = 4'h1,
    S_RUN    = 4'h2,
    S_SWITCH = 4'h4,
    S_WAIT   = 4'h8
  } sched_state_t;

  typedef enum logic [1:0] {
    CL_ALU    = 2'h0,
    CL_LSHARE = 2'h1,
    CL_FETCH  = 2'h2,
    CL_STORE  = 2'h3
  } op_class_t;

endpackage

/* rtl/wave_rr_arbiter.sv */
/*
  Round-robin pick of one ready wavefront.
  Assumes req is stable in the cycle adv is raised.
*/
`timescale 1ns/1ns
`default_nettype none

module wave_rr_arbiter #(
  parameter int N = 4,
  parameter int W = $clog2(N)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N-1:0] req,
  input wire logic adv,
  output logic [W-1:0] gnt_idx,
  output logic gnt_any
);

  logic [W-1:0] ptr_r;

  // the last winner has the lowest priority next time
  always_comb begin
    gnt_idx = '0;
    gnt_any = 1'b0;
    for (int i = N; i >= 1; i--) begin
      if (req[(int'(ptr_r) + i) % N]) begin
        gnt_idx = W'((int'(ptr_r) + i) % N); // see [RULE_17]
        gnt_any = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_r <= '0;
    end else if (adv && gnt_any) begin
      ptr_r <= gnt_idx;
    end
  end

  a_rr_rotate: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_17]
    gnt_any && req[ptr_r] && $countones(req) > 1 |-> gnt_idx != ptr_r)
    else $error("round robin granted the last winner again");

endmodule

`default_nettype wire

/* rtl/issue_word_packer.sv */
/*
  Packs accepted operations into wide issue words of SLOTS slots.
  Assumes op_take and flush never rise in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module issue_word_packer #(
  parameter int SLOTS = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_take,
  input wire logic op_dep,
  input wire logic op_mul32,
  input wire logic op_mad,
  input wire logic op_addr,
  input wire logic flush,
  output logic word_valid_r,
  output logic [SLOTS-1:0] word_fill_r,
  output logic [SLOTS-1:0] word_mad_r,
  output logic [SLOTS-1:0] word_addr_r
);

  localparam int CW = $clog2(SLOTS + 1);

  logic [CW-1:0] cnt_r;
  logic [SLOTS-1:0] fill_r;
  logic [SLOTS-1:0] mad_r;
  logic [SLOTS-1:0] addr_r;
  logic m32_r;

  // -----------------------------------------------------------------
  // word breaks
  // -----------------------------------------------------------------
  wire full = (cnt_r == CW'(SLOTS));
  wire clash = op_mul32 & m32_r; // see [RULE_15]
  wire brk = op_take & (cnt_r != '0) & (full | op_dep | clash); // see [RULE_13]
  wire emit = brk | (flush & (cnt_r != '0));
  wire [CW-1:0] base = emit ? '0 : cnt_r;
  wire [SLOTS-1:0] bit_sel = op_take ? (SLOTS'(1) << base) : '0;
  wire [SLOTS-1:0] fill_keep = emit ? '0 : fill_r;
  wire [SLOTS-1:0] mad_keep = emit ? '0 : mad_r;
  wire [SLOTS-1:0] addr_keep = emit ? '0 : addr_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      fill_r <= '0;
      mad_r <= '0;
      addr_r <= '0;
      m32_r <= 1'b0;
    end else if (emit || op_take) begin
      cnt_r <= op_take ? base + 1'b1 : '0;
      fill_r <= fill_keep | bit_sel;
      mad_r <= mad_keep | (op_mad ? bit_sel : '0); // see [RULE_14]
      addr_r <= addr_keep | (op_addr ? bit_sel : '0); // see [RULE_12]
      m32_r <= (m32_r & ~emit) | (op_take & op_mul32);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_valid_r <= 1'b0;
      word_fill_r <= '0;
      word_mad_r <= '0;
      word_addr_r <= '0;
    end else begin
      word_valid_r <= emit;
      if (emit) begin
        word_fill_r <= fill_r;
        word_mad_r <= mad_r;
        word_addr_r <= addr_r;
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_word_width: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_13]
    op_take && op_dep && cnt_r != '0 |=> word_valid_r && cnt_r == CW'(1))
    else $error("dependent op shared a word");
  a_mul32_single: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_15]
    op_take && op_mul32 && m32_r |=> word_valid_r && m32_r)
    else $error("two 32-bit multiplies in one word");
  a_mad_in_slot: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_14]
    word_valid_r |-> (word_mad_r & ~word_fill_r) == '0)
    else $error("multiply-add mark outside filled slots");
  a_addr_on_alu: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE_12]
    op_take && op_addr |=> (addr_r & fill_r) != '0)
    else $error("address op took no arithmetic slot");

endmodule

`default_nettype wire

/* rtl/clause_wavefront_scheduler.sv */
/*
  Clause formation and wavefront scheduling for one compute unit.
  Assumes the instruction source presents the next instruction of
  the wavefront shown on WAVE_ID, and keeps it standing until taken.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sched_defs.svh"

// Operation
// [RULE_01] close the clause when the next instruction changes class
// [RULE_02] an arithmetic clause ends after 128 operations
// [RULE_03] arithmetic and local share accesses share one clause
// [RULE_04] fetch, arithmetic and store never mix within a clause
// [RULE_05] run even wavefront four quarter cycles, then odd four cycles
// [RULE_06] idle member reads operands, hiding eight-cycle register reads
// [RULE_07] change wavefront only at a clause boundary
// [RULE_08] local share conflicts stall in place, no wavefront switch
// [RULE_09] marked arithmetic clause waits for all its fetches to finish
// [RULE_10] same-wavefront clause switch costs 40 cycles
// [RULE_11] at a boundary dispatch another ready wavefront at once
// [RULE_12] fetch and store address work uses arithmetic issue slots
// [RULE_13] issue words of five slots, dependent ops in separate words
// [RULE_14] multiply-add rounds after multiply and again after add
// [RULE_15] one 32-bit multiply per word, 24-bit ones in every slot
// [RULE_16] no packed 16-bit or 8-bit operations, only 32-bit
// [RULE_17] ready wavefronts are picked in round-robin order
module clause_wavefront_scheduler #(
  parameter int NW = `WAVE_COUNT,
  parameter int SLOTS = `ISSUE_SLOTS,
  parameter int ALU_MAX = `ALU_CLAUSE_MAX,
  parameter int SW_CYC = `CLAUSE_SWITCH_CYC,
  parameter int FCW = `FETCH_CNT_W
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic INSTR_VALID,
  input wire logic [1:0] INSTR_CLASS,
  input wire logic INSTR_SER_DEP,
  input wire logic INSTR_MUL32,
  input wire logic INSTR_MAD,
  input wire logic INSTR_PACKED,
  input wire logic INSTR_FETCH_DEP,
  input wire logic LSHARE_BUSY,
  input wire logic FETCH_DONE,
  input wire logic [NW-1:0] WAVE_READY,
  output logic INSTR_READY,
  output logic [$clog2(NW)-1:0] WAVE_ID,
  output logic DISPATCH,
  output logic CLAUSE_END,
  output logic [1:0] CLAUSE_KIND,
  output logic [$clog2(ALU_MAX+1)-1:0] CLAUSE_LEN,
  output logic SWITCHING,
  output logic FETCH_WAIT,
  output logic [FCW-1:0] FETCH_PENDING,
  output logic EXEC_ODD,
  output logic [1:0] QUARTER,
  output logic STAGE_ODD,
  output logic OP_REJECT,
  output logic WORD_VALID,
  output logic [SLOTS-1:0] WORD_FILL,
  output logic [SLOTS-1:0] WORD_MAD,
  output logic [SLOTS-1:0] WORD_ADDR
);

  localparam int WW = $clog2(NW);
  localparam int LW = $clog2(ALU_MAX + 1);
  localparam int TW = $clog2(SW_CYC + 1);
  localparam int PW = $clog2(`REG_READ_LAT);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  sched_pkg::sched_state_t state_r;
  sched_pkg::sched_state_t state_nxt;
  sched_pkg::op_class_t cls_in;
  sched_pkg::op_class_t kind_in;
  sched_pkg::op_class_t kind_r;
  logic open_r;
  logic [LW-1:0] len_r;
  logic [WW-1:0] wave_r;
  logic [PW-1:0] phase_r;
  logic [FCW-1:0] fcnt_r;
  logic ready_r;
  logic disp_r;
  logic cend_r;
  logic rej_r;
  logic sw_r;
  logic wait_r;
  logic stage_r;
  logic go_disp;
  logic [TW-1:0] sw_len_r;
  logic [NW-1:0] elig;
  logic [NW-1:0] tmr_zero;
  logic [WW-1:0] gnt_idx;
  logic gnt_any;

  // -----------------------------------------------------------------
  // instruction decode
  // -----------------------------------------------------------------
  assign cls_in = sched_pkg::op_class_t'(INSTR_CLASS);
  // local share accesses ride in the arithmetic clause
  assign kind_in = (cls_in == sched_pkg::CL_LSHARE) ? sched_pkg::CL_ALU : cls_in; // see [RULE_03]

  wire run = (state_r == sched_pkg::S_RUN);
  wire offer = INSTR_VALID & ready_r & ~LSHARE_BUSY; // see [RULE_08]
  wire rej = offer & INSTR_PACKED; // see [RULE_16]
  wire legal = offer & ~INSTR_PACKED;
  wire cap_hit = (kind_r == sched_pkg::CL_ALU) & (len_r == LW'(ALU_MAX)); // see [RULE_02]
  wire kind_chg = (kind_in != kind_r); // see [RULE_01]
  wire close_ev = legal & open_r & (kind_chg | cap_hit); // see [RULE_04]
  wire dep_blk = legal & ~open_r & (kind_in == sched_pkg::CL_ALU)
    & INSTR_FETCH_DEP & (fcnt_r != '0); // see [RULE_09]
  wire take = legal & ~close_ev & ~dep_blk;
  wire is_mem = (kind_in == sched_pkg::CL_FETCH) | (kind_in == sched_pkg::CL_STORE);
  wire fetch_inc = take & (kind_in == sched_pkg::CL_FETCH);
  wire fetch_dec = FETCH_DONE & ((fcnt_r != '0) | fetch_inc);
  wire adv_ph = run & ~LSHARE_BUSY; // see [RULE_08]
  wire [PW-1:0] phase_nxt = adv_ph ? phase_r + 1'b1 : phase_r;
  wire cur_zero = tmr_zero[wave_r];

  // -----------------------------------------------------------------
  // per-wavefront switch timers
  // -----------------------------------------------------------------
  for (genvar w = 0; w < NW; w++) begin : g_wave
    logic [TW-1:0] cnt_r;
    wire cur = (wave_r == WW'(w));
    assign tmr_zero[w] = (cnt_r == '0);
    // the running wavefront is never offered to itself
    assign elig[w] = WAVE_READY[w] & tmr_zero[w] & ~(cur & (state_r != sched_pkg::S_IDLE));
    always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
        cnt_r <= '0;
      end else if (close_ev && cur) begin
        cnt_r <= TW'(SW_CYC - 1); // see [RULE_10]
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  wave_rr_arbiter #(
    .N(NW),
    .W(WW)
  ) u_arb (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .req(elig),
    .adv(go_disp),
    .gnt_idx(gnt_idx),
    .gnt_any(gnt_any)
  );

  // -----------------------------------------------------------------
  // scheduler state machine
  // -----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    go_disp = 1'b0;
    unique case (state_r)
      sched_pkg::S_IDLE: begin
        if (gnt_any) begin
          state_nxt = sched_pkg::S_RUN;
          go_disp = 1'b1;
        end
      end
      sched_pkg::S_RUN: begin
        if (close_ev) begin
          if (gnt_any) begin
            go_disp = 1'b1; // see [RULE_11]
          end else begin
            state_nxt = sched_pkg::S_SWITCH; // see [RULE_10]
          end
        end else if (dep_blk) begin
          state_nxt = sched_pkg::S_WAIT; // see [RULE_09]
        end
      end
      sched_pkg::S_SWITCH: begin
        if (gnt_any) begin
          state_nxt = sched_pkg::S_RUN; // see [RULE_11]
          go_disp = 1'b1;
        end else if (cur_zero) begin
          state_nxt = WAVE_READY[wave_r] ? sched_pkg::S_RUN : sched_pkg::S_IDLE;
        end
      end
      sched_pkg::S_WAIT: begin
        if (fcnt_r == '0) begin
          state_nxt = sched_pkg::S_RUN;
        end
      end
      default: begin
        state_nxt = sched_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_r <= sched_pkg::S_IDLE;
      ready_r <= 1'b0;
      sw_r <= 1'b0;
      wait_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == sched_pkg::S_RUN);
      sw_r <= (state_nxt == sched_pkg::S_SWITCH);
      wait_r <= (state_nxt == sched_pkg::S_WAIT);
    end
  end

  // wavefront identity changes only on a dispatch
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wave_r <= '0;
      disp_r <= 1'b0;
    end else begin
      disp_r <= go_disp;
      if (go_disp) begin
        wave_r <= gnt_idx; // see [RULE_07]
      end
    end
  end

  // -----------------------------------------------------------------
  // clause tracking
  // -----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      open_r <= 1'b0;
      kind_r <= sched_pkg::CL_ALU;
      len_r <= '0;
    end else if (close_ev) begin
      open_r <= 1'b0; // see [RULE_01]
    end else if (take) begin
      open_r <= 1'b1;
      kind_r <= kind_in;
      len_r <= open_r ? len_r + 1'b1 : LW'(1);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cend_r <= 1'b0;
      rej_r <= 1'b0;
      fcnt_r <= '0;
    end else begin
      cend_r <= close_ev;
      rej_r <= rej;
      fcnt_r <= fcnt_r + FCW'(fetch_inc) - FCW'(fetch_dec);
    end
  end

  // -----------------------------------------------------------------
  // even/odd pair cadence
  // -----------------------------------------------------------------
  // the member not executing stages operands over the same 4 cycles
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      phase_r <= '0;
      stage_r <= 1'b1;
    end else begin
      phase_r <= phase_nxt; // see [RULE_05]
      stage_r <= ~phase_nxt[PW-1]; // see [RULE_06]
    end
  end

  // -----------------------------------------------------------------
  // issue word packing
  // -----------------------------------------------------------------
  issue_word_packer #(
    .SLOTS(SLOTS)
  ) u_pack (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .op_take(take),
    .op_dep(INSTR_SER_DEP),
    .op_mul32(INSTR_MUL32),
    .op_mad(INSTR_MAD),
    .op_addr(is_mem),
    .flush(close_ev),
    .word_valid_r(WORD_VALID),
    .word_fill_r(WORD_FILL),
    .word_mad_r(WORD_MAD),
    .word_addr_r(WORD_ADDR)
  );

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign INSTR_READY = ready_r;
  assign WAVE_ID = wave_r;
  assign DISPATCH = disp_r;
  assign CLAUSE_END = cend_r;
  assign CLAUSE_KIND = kind_r;
  assign CLAUSE_LEN = len_r;
  assign SWITCHING = sw_r;
  assign FETCH_WAIT = wait_r;
  assign FETCH_PENDING = fcnt_r;
  assign EXEC_ODD = phase_r[PW-1];
  assign QUARTER = phase_r[1:0];
  assign STAGE_ODD = stage_r;
  assign OP_REJECT = rej_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || state_r != sched_pkg::S_SWITCH) begin
      sw_len_r <= '0;
    end else begin
      sw_len_r <= sw_len_r + 1'b1;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  a_class_close: assert property ( // see [RULE_01]
    legal && open_r && kind_chg |=> cend_r && !open_r)
    else $error("class change did not close the clause");
  a_alu_len_cap: assert property ( // see [RULE_02]
    (len_r <= LW'(ALU_MAX)) and (legal && open_r && cap_hit |=> cend_r))
    else $error("arithmetic clause ran past its limit");
  a_lshare_joins: assert property ( // see [RULE_03]
    take && open_r && kind_r == sched_pkg::CL_ALU && cls_in == sched_pkg::CL_LSHARE
    |=> open_r && !cend_r)
    else $error("local share op split the clause");
  a_kinds_apart: assert property ( // see [RULE_04]
    take && open_r |-> kind_in == kind_r)
    else $error("mixed classes within one clause");
  a_pair_order: assert property ( // see [RULE_05]
    adv_ph && phase_r == PW'(3) |=> EXEC_ODD && QUARTER == 2'h0)
    else $error("odd member did not follow four even cycles");
  a_read_overlap: assert property ( // see [RULE_06]
    adv_ph && phase_r == '0 ##1 adv_ph [*7] |=> phase_r == '0 && STAGE_ODD)
    else $error("pair cadence does not span eight cycles");
  a_no_mid_switch: assert property ( // see [RULE_07]
    !$stable(wave_r) |-> $past(close_ev) || $past(state_r) != sched_pkg::S_RUN)
    else $error("wavefront changed inside a clause");
  a_busy_stall: assert property ( // see [RULE_08]
    LSHARE_BUSY && run |=> phase_r == $past(phase_r) && $stable(wave_r) && !cend_r)
    else $error("local share stall was not held in place");
  a_fetch_dep: assert property ( // see [RULE_09]
    take && !open_r && kind_in == sched_pkg::CL_ALU && INSTR_FETCH_DEP |-> fcnt_r == '0)
    else $error("dependent clause began with fetches pending");
  a_switch_cost: assert property ( // see [RULE_10]
    state_r == sched_pkg::S_SWITCH && state_nxt == sched_pkg::S_RUN && !go_disp
    |-> sw_len_r == TW'(SW_CYC - 1) && !ready_r)
    else $error("clause switch did not take its cycles");
  a_hide_switch: assert property ( // see [RULE_11]
    close_ev && gnt_any |=> run && disp_r && wave_r != $past(wave_r))
    else $error("ready wavefront was not dispatched at once");
  a_packed_reject: assert property ( // see [RULE_16]
    rej |=> OP_REJECT && $stable(len_r))
    else $error("packed narrow op was not rejected");

  c_other_wave: cover property (close_ev && gnt_any);
  c_same_wave: cover property (close_ev && !gnt_any ##1 sw_r);
  c_fetch_wait: cover property (dep_blk ##1 wait_r);
  c_clause_full: cover property (close_ev && cap_hit && !kind_chg);

endmodule

`default_nettype wire

/* test/fetch_return_unit.sv */
/*
  Memory fetch unit model: returns one completion pulse per outstanding
  fetch, after a programmable gap. Assumes the pending count it watches
  counts fetches in flight.
*/
`timescale 1ns/1ns
`default_nettype none

module fetch_return_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] pending,
  input wire logic [3:0] gap,
  output logic done
);
  logic [3:0] wait_r;

  // one completion, then restart the gap so a pulse is never counted twice
  always_ff @(posedge clk) begin
    if (!rst_n || pending == 8'h0 || done) begin
      wait_r <= 4'h0;
      done <= 1'h0;
    end else begin
      wait_r <= wait_r + 4'h1;
      done <= wait_r >= gap;
    end
  end
endmodule

`default_nettype wire

/* test/clause_wavefront_scheduler_bench.sv */
/*
  Self-checking bench with an integer clause and fetch model.
  Assumes sched_pkg, the scheduler and fetch_return_unit are compiled.
*/
`timescale 1ns/1ns
`default_nettype none

module clause_wavefront_scheduler_bench;
  localparam int SW = 4;
  logic SYS_CLK = 0, RST_N = 0, INSTR_VALID = 0, INSTR_SER_DEP = 0, INSTR_MUL32 = 0, INSTR_MAD = 0;
  logic INSTR_PACKED = 0, INSTR_FETCH_DEP = 0, LSHARE_BUSY = 0;
  logic [1:0] INSTR_CLASS = 0;
  logic [3:0] WAVE_READY = 0, gap = 0;
  wire logic FETCH_DONE, INSTR_READY, DISPATCH, CLAUSE_END, SWITCHING, FETCH_WAIT, EXEC_ODD, STAGE_ODD;
  wire logic OP_REJECT, WORD_VALID;
  wire logic [1:0] WAVE_ID, CLAUSE_KIND, QUARTER;
  wire logic [7:0] CLAUSE_LEN, FETCH_PENDING;
  wire logic [4:0] WORD_FILL, WORD_MAD, WORD_ADDR;
  int failures = 0, tests_run = 0, cyc = 0, mlen = 0, pend = 0, swc = 0;
  int q[$];
  logic [1:0] mkind = 0, grp, pwid;
  logic [2:0] ph;
  bit open = 0, tk = 0, rej = 0, two = 0, bsy = 0, seen = 0, pbusy = 0;
  int wn = 0;
  logic [4:0] wf = 0, wm = 0, wa = 0, ef = 0, em = 0, ea = 0;
  bit w32 = 0, ewv = 0;

  clause_wavefront_scheduler #(.SW_CYC(SW)) i_clause_wavefront_scheduler (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID), .INSTR_CLASS(INSTR_CLASS),
    .INSTR_SER_DEP(INSTR_SER_DEP), .INSTR_MUL32(INSTR_MUL32), .INSTR_MAD(INSTR_MAD),
    .INSTR_PACKED(INSTR_PACKED), .INSTR_FETCH_DEP(INSTR_FETCH_DEP), .LSHARE_BUSY(LSHARE_BUSY),
    .FETCH_DONE(FETCH_DONE), .WAVE_READY(WAVE_READY), .INSTR_READY(INSTR_READY), .WAVE_ID(WAVE_ID),
    .DISPATCH(DISPATCH), .CLAUSE_END(CLAUSE_END), .CLAUSE_KIND(CLAUSE_KIND), .CLAUSE_LEN(CLAUSE_LEN),
    .SWITCHING(SWITCHING), .FETCH_WAIT(FETCH_WAIT), .FETCH_PENDING(FETCH_PENDING), .EXEC_ODD(EXEC_ODD),
    .QUARTER(QUARTER), .STAGE_ODD(STAGE_ODD), .OP_REJECT(OP_REJECT), .WORD_VALID(WORD_VALID),
    .WORD_FILL(WORD_FILL), .WORD_MAD(WORD_MAD), .WORD_ADDR(WORD_ADDR));

  fetch_return_unit i_fetch_return_unit (
    .clk(SYS_CLK), .rst_n(RST_N), .pending(FETCH_PENDING), .gap(gap), .done(FETCH_DONE));

  always #50 SYS_CLK = ~SYS_CLK;

  task check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: saw %0h want %0h", $time, s, e);
    end
  endtask

  task give_verdict;
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hands the word being filled over as the expected emitted word
  task emit_word;
    ewv = 1;
    ef = wf;
    em = wm;
    ea = wa;
    wn = 0;
    wf = 0;
    wm = 0;
    wa = 0;
    w32 = 0;
  endtask

  // ---------------------------------------------------------------
  // model: checks the last edge, then predicts the coming one
  // ---------------------------------------------------------------
  always @(negedge SYS_CLK) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      give_verdict;
    end else begin
      if (!RST_N) begin
        open = 0;
        mlen = 0;
        mkind = 0;
        pend = 0;
        rej = 0;
        seen = 0;
        swc = 0;
        q = {};
        emit_word;
        ewv = 0;
      end else begin
        check(CLAUSE_LEN, mlen);
        check(CLAUSE_KIND, mkind);
        check(FETCH_PENDING, pend);
        check(OP_REJECT, rej);
        check(STAGE_ODD ^ EXEC_ODD, 1);
        if ({EXEC_ODD, QUARTER} !== ph) check({EXEC_ODD, QUARTER}, pbusy ? ph : 3'(ph + 3'h1));
        if (seen && WAVE_ID !== pwid) check(CLAUSE_END, 1);
        if (DISPATCH) seen = 1;
        if (FETCH_WAIT) check(INSTR_READY | SWITCHING, 0);
        if (WORD_VALID) check((WORD_MAD | WORD_ADDR) & ~WORD_FILL, 0);
        check(WORD_VALID, ewv);
        if (ewv) check(WORD_FILL, ef);
        if (ewv) check(WORD_MAD, em);
        if (ewv) check(WORD_ADDR, ea);
        if (CLAUSE_END) begin
          check(CLAUSE_LEN, q.size() > 0 ? q.pop_front() : -1);
          check(two ? DISPATCH : SWITCHING, 1);
          if (two) check(WAVE_ID, {1'h0, ~pwid[0]});
        end
        if (SWITCHING) begin
          swc++;
          check(INSTR_READY, 0);
        end else if (swc > 0) begin
          check(swc, SW);
          swc = 0;
        end
        rej = 0;
        tk = 0;
        ewv = 0;
        grp = INSTR_CLASS == sched_pkg::CL_LSHARE ? sched_pkg::CL_ALU : INSTR_CLASS;
        if (INSTR_VALID && INSTR_READY && !LSHARE_BUSY) begin
          if (INSTR_PACKED) begin
            rej = 1;
            tk = 1;
          end else if (open && (grp != mkind || (grp == sched_pkg::CL_ALU && mlen == 128))) begin
            q.push_back(mlen);
            open = 0;
            if (wn > 0) emit_word;
          end else if (open || grp != sched_pkg::CL_ALU || !INSTR_FETCH_DEP || pend == 0) begin
            tk = 1;
            mlen = open ? mlen + 1 : 1;
            mkind = grp;
            open = 1;
            if (grp == sched_pkg::CL_FETCH) pend++;
            if (wn > 0 && (wn == 5 || INSTR_SER_DEP || INSTR_MUL32 && w32)) emit_word;
            wf[wn] = 1'b1;
            wm[wn] = INSTR_MAD;
            wa[wn] = grp == sched_pkg::CL_FETCH || grp == sched_pkg::CL_STORE;
            w32 = w32 | INSTR_MUL32;
            wn++;
          end
        end
        if (FETCH_DONE && pend > 0) pend--;
      end
      pbusy = LSHARE_BUSY;
      ph = {EXEC_ODD, QUARTER};
      pwid = WAVE_ID;
    end
  end

  // ---------------------------------------------------------------
  // instruction source: holds each op until the model sees it taken or rejected
  // ---------------------------------------------------------------
  task offer(input logic [1:0] c, input bit fd, input bit pk);
    INSTR_VALID <= 1'h1;
    INSTR_CLASS <= c;
    INSTR_FETCH_DEP <= fd;
    INSTR_PACKED <= pk;
    INSTR_SER_DEP <= $urandom % 4 == 0;
    INSTR_MUL32 <= $urandom % 4 == 0;
    INSTR_MAD <= $urandom % 3 == 0;
    do begin
      LSHARE_BUSY <= bsy && $urandom % 3 == 0;
      @(posedge SYS_CLK);
    end while (!tk);
  endtask

  task clause(input logic [1:0] c, input int n, input bit fd);
    for (int i = 0; i < n; i++) begin
      offer(c == sched_pkg::CL_ALU && $urandom % 2 ? sched_pkg::CL_LSHARE : c, fd && i == 0, 0);
    end
  endtask

  initial begin
    void'($urandom(24));
    WAVE_READY = 4'h1;
    repeat (5) @(posedge SYS_CLK);
    check({INSTR_READY, DISPATCH, CLAUSE_END, STAGE_ODD}, 4'h1);
    RST_N <= 1'h1;
    gap <= 4'h6;
    offer(sched_pkg::CL_ALU, 0, 1);
    clause(sched_pkg::CL_ALU, 6, 0);
    clause(sched_pkg::CL_FETCH, 3, 0);
    clause(sched_pkg::CL_ALU, 5, 1);
    clause(sched_pkg::CL_STORE, 2, 0);
    bsy = 1;
    clause(sched_pkg::CL_ALU, 130, 0);
    bsy = 0;
    gap <= 4'h1;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        WAVE_READY <= 4'h3;
        two = 1;
      end
      clause(k % 2 ? sched_pkg::CL_STORE : sched_pkg::CL_ALU, 6 + $urandom % 8, 0);
    end
    INSTR_VALID <= 1'h0;
    LSHARE_BUSY <= 1'h0;
    repeat (20) @(posedge SYS_CLK);
    give_verdict;
  end
endmodule

`default_nettype wire
